// file: sccsr_pkg.sv
// Purpose: Shared constants and carriers for the system config/state bank
// Assumes: Register IDs are the frame address field, data is 20 bits
// Notes: Struct layouts mirror the register bit order, MSB first
package sccsr_pkg;

	localparam int ADDR_W = 7;
	localparam int DATA_W = 20;

	// Register IDs
	localparam logic [6:0] ID_SYS_CONFIG = 7'h01;
	localparam logic [6:0] ID_SYS_CONTROL = 7'h02;
	localparam logic [6:0] ID_SLEEP_COMMAND = 7'h03;
	localparam logic [6:0] ID_PHASE_REPORT = 7'h04;
	localparam logic [6:0] ID_POWER_STATUS = 7'h05;

	// Configuration register, bits 15:0
	typedef struct packed {
		logic auto_switch_off_enable;
		logic rsvd14;
		logic low_current_mode;
		logic reserve_boost_hold_in_reserve;
		logic passenger_inhibit_source_select;
		logic high_level_check_duration;
		logic remote_sensor_pulse_shift_duration;
		logic [1:0] squib_dc_sample_count;
		logic [1:0] voltage_sample_count;
		logic passenger_inhibit_measure_mode;
		logic safing_engine_source_select;
		logic safing_supply_voltage_select;
		logic input_good_fall_filter_select;
		logic first_watchdog_initial_timeout_disable;
	} sccsr_cfg_t;

	// Control register, bits 15:0
	typedef struct packed {
		logic pulse_boost_restart_source;
		logic pull_down_level_select;
		logic pulse_boost_hold_in_reserve;
		logic input_threshold_select;
		logic [1:0] battery_monitor_threshold_select;
		logic reserve_boost_voltage_select;
		logic [1:0] reserve_charge_control;
		logic reserve_boost_on_request;
		logic pulse_boost_on_request;
		logic power_off_request;
		logic rsvd3;
		logic reserve_switch_limit_select;
		logic pulse_boost_voltage_select;
		logic sensor_buck_voltage_select;
	} sccsr_ctl_t;

	// Comparator levels arriving from the analog side
	typedef struct packed {
		logic boost_below_restart;
		logic boost_above_restart;
		logic input_fast_slope;
		logic logic_supply_over;
		logic logic_supply_under;
		logic reserve_boost_low;
		logic sensor_buck_low;
		logic pulse_boost_low;
		logic not_input_good;
		logic input_bad;
		logic not_battery_good;
		logic battery_bad;
		logic wake_pin;
	} sccsr_cmp_t;

	// Reset values, write masks and per-source reset masks
	localparam logic [15:0] CFG_RST = 16'h1808;
	localparam logic [15:0] CFG_WMASK = 16'hBFFF;
	localparam logic [15:0] CFG_SSM_MASK = 16'hBFFC;
	localparam logic [15:0] CFG_WSM_MASK = 16'hBFFD;
	localparam logic [15:0] CTL_RST = 16'h2060;
	localparam logic [15:0] CTL_WMASK = 16'hFFE7;
	localparam logic [15:0] CTL_SSM_MASK = 16'hFFF3;
	localparam logic [15:0] POWER_OFF_BIT = 16'h0010;

	// Phase codes
	localparam logic [2:0] OPER_FIRST = 3'h0;
	localparam logic [2:0] POWER_WAKE = 3'h0;
	localparam logic [2:0] POWER_RESERVE = 3'h3;
	localparam logic [2:0] POWER_SHUTDOWN = 3'h4;

	// Sample counts per conversion
	localparam logic [4:0] SAMPLES_1 = 5'h01;
	localparam logic [4:0] SAMPLES_2 = 5'h02;
	localparam logic [4:0] SAMPLES_4 = 5'h04;
	localparam logic [4:0] SAMPLES_8 = 5'h08;
	localparam logic [4:0] SAMPLES_16 = 5'h10;

	// Input-good filter times
	localparam int CLK_MHZ = 125;
	localparam int FILT_SHORT_NS = 1000;
	localparam int FILT_LONG_NS = 3500;
	localparam int FILT_SHORT_CYC = (FILT_SHORT_NS * CLK_MHZ + 999) / 1000;
	localparam int FILT_LONG_CYC = (FILT_LONG_NS * CLK_MHZ + 999) / 1000;

	typedef enum logic [3:0] {
		BST_FOLLOW = 4'b0001,
		BST_RUN = 4'b0010,
		BST_WAIT = 4'b0100,
		BST_ARMED = 4'b1000
	} sccsr_bst_state_t;

endpackage

// file: sccsr_sticky.sv
// Purpose: Bank of latched flags cleared as a group
// Assumes: Set and clear come from the same clock domain
// Notes: A set in the clearing cycle survives
`timescale 1ns/10ps
`default_nettype none
module sccsr_sticky #(
	parameter int W = 4
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [W-1:0] set,
	input wire logic clr,
	output logic [W-1:0] q
);
	logic [W-1:0] q_reg;
	logic [W-1:0] q_next;

	assign q_next = set | (q_reg & ~{W{clr}});
	assign q = q_reg;

	always_ff @(posedge clk) begin
		if (srst) begin
			q_reg <= '0;
		end else begin
			q_reg <= q_next;
		end
	end
endmodule
`default_nettype wire

// file: sccsr_regs.sv
// Purpose: System configuration, control, sleep, phase and power status bank
// Assumes: Frame decoding is done outside; one access per reg_wr/reg_rd
// Notes: srst is the power-on reset; the machine resets are 1-cycle pulses
//
// Function
// - Squib/sensor/temperature sample code 00=8,01=16,10=4,11=2; resets 00.
// - Other voltage sample code 00=4,01=16,10=8,11=1; resets 00.
// - Passenger inhibit source: 0 internal, 1 external; resets to 1.
// - Safing engine source: 0 internal, 1 external; resets to 1.
// - Input-good fall filter 1 us or 3.5 us; rise always 3.5 us.
// - Watchdog initial timeout disable bit; reset by watchdog machine reset.
// - High-level check duration: 0 short, 1 long; resets 0.
// - Remote sensor pulse shift: 0 long, 1 short; resets 0.
// - Passenger inhibit measurement: 0 current, 1 voltage; resets 0.
// - Safing supply select: 0 gives 20 V, 1 gives 25 V.
// - Reserve restart: 0 fast-slope input, 1 boost falls after exceeding.
// - Hold bit keeps pulse boost on in reserve; writing 1 restarts.
// - Battery threshold 00/11 -> 0, 01 -> 1, 10 -> 2; input select 0/1.
// - Charge control: 00/11 off, 01 charge, 10 discharge; resets 00.
// - Reserve boost select: 0 gives 23 V, 1 gives 33 V.
// - Reserve and pulse boost requests: 0 off, 1 on; reset to 1.
// - Power-off write of 1 acts only in shutdown phase; 0 no effect.
// - Pulse boost 12 V / 14.75 V, sensor buck 7.2 V / 9 V selects.
// - Sleep register write is a one-shot command allowing shutdown.
// - Operating phase code reported, reset on all three sources.
// - Power phase code reported, reset on power-on only.
// - Four supply flags latch and clear on read; others are live.
`timescale 1ns/10ps
`default_nettype none
module sccsr_regs #(
	parameter int FILT_W = 10
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic safing_machine_reset,
	input wire logic watchdog_machine_reset,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [sccsr_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [sccsr_pkg::DATA_W-1:0] reg_wdata,
	output logic [sccsr_pkg::DATA_W-1:0] reg_rdata,
	output logic reg_rvalid,
	output logic reg_unmapped,
	input wire logic [2:0] operating_phase_code,
	input wire logic [2:0] power_phase_code,
	input wire logic [8:0] power_activity,
	input wire sccsr_pkg::sccsr_cmp_t cmp_pins,
	output sccsr_pkg::sccsr_cfg_t cfg,
	output sccsr_pkg::sccsr_ctl_t ctl,
	output logic [4:0] squib_dc_samples,
	output logic [4:0] voltage_samples,
	output logic [FILT_W-1:0] input_good_fall_filter_cycles,
	output logic [FILT_W-1:0] input_good_rise_filter_cycles,
	output logic first_watchdog_initial_timeout_enable,
	output logic [1:0] battery_monitor_threshold_index,
	output logic reserve_charge_enable,
	output logic reserve_discharge_enable,
	output logic pulse_boost_enable,
	output logic power_off_pulse,
	output logic sleep_pulse
);
	localparam logic [FILT_W-1:0] FALL_SHORT =
		FILT_W'(sccsr_pkg::FILT_SHORT_CYC);
	localparam logic [FILT_W-1:0] FALL_LONG =
		FILT_W'(sccsr_pkg::FILT_LONG_CYC);

	sccsr_pkg::sccsr_cfg_t cfg_reg;
	sccsr_pkg::sccsr_cfg_t cfg_next;
	sccsr_pkg::sccsr_ctl_t ctl_reg;
	sccsr_pkg::sccsr_ctl_t ctl_next;
	sccsr_pkg::sccsr_cmp_t cmp_meta_reg;
	sccsr_pkg::sccsr_cmp_t cmp_sync_reg;
	sccsr_pkg::sccsr_bst_state_t bst_reg;
	sccsr_pkg::sccsr_bst_state_t bst_next;

	logic [2:0] oper_phase_reg;
	logic [2:0] power_phase_reg;
	logic [sccsr_pkg::DATA_W-1:0] reg_rdata_reg;
	logic [sccsr_pkg::DATA_W-1:0] reg_rdata_next;
	logic reg_rvalid_reg;
	logic reg_unmapped_reg;
	logic [4:0] squib_samples_reg;
	logic [4:0] squib_samples_next;
	logic [4:0] voltage_samples_reg;
	logic [4:0] voltage_samples_next;
	logic [FILT_W-1:0] fall_filter_reg;
	logic wd_timeout_enable_reg;
	logic [1:0] batt_index_reg;
	logic [1:0] batt_index_next;
	logic charge_reg;
	logic discharge_reg;
	logic pulse_boost_reg;
	logic pulse_boost_next;
	logic power_off_reg;
	logic sleep_reg;
	logic [3:0] flags_q;

	// Decode
	wire hit_cfg = reg_addr == sccsr_pkg::ID_SYS_CONFIG;
	wire hit_ctl = reg_addr == sccsr_pkg::ID_SYS_CONTROL;
	wire hit_sleep = reg_addr == sccsr_pkg::ID_SLEEP_COMMAND;
	wire hit_phase = reg_addr == sccsr_pkg::ID_PHASE_REPORT;
	wire hit_power = reg_addr == sccsr_pkg::ID_POWER_STATUS;
	wire hit_any = hit_cfg | hit_ctl | hit_sleep | hit_phase | hit_power;
	wire wr_cfg = reg_wr & hit_cfg;
	wire wr_ctl = reg_wr & hit_ctl;
	wire wr_sleep = reg_wr & hit_sleep;
	wire rd_power = reg_rd & hit_power;
	wire in_shutdown = power_phase_code == sccsr_pkg::POWER_SHUTDOWN;
	wire in_reserve = power_phase_code == sccsr_pkg::POWER_RESERVE;

	// Power-off only in shutdown; a same-cycle safing reset wins
	wire power_off_write = wr_ctl & in_shutdown &
		reg_wdata[4] & ~safing_machine_reset;
	wire [15:0] ctl_wmask = in_shutdown ?
		(sccsr_pkg::CTL_WMASK | sccsr_pkg::POWER_OFF_BIT) :
		sccsr_pkg::CTL_WMASK;

	// Configuration next value: write, then machine resets on top
	wire [15:0] cfg_wr_val = wr_cfg ?
		((cfg_reg & ~sccsr_pkg::CFG_WMASK) |
		(reg_wdata[15:0] & sccsr_pkg::CFG_WMASK)) : cfg_reg;
	wire [15:0] cfg_ssm_val = safing_machine_reset ?
		((cfg_wr_val & ~sccsr_pkg::CFG_SSM_MASK) |
		(sccsr_pkg::CFG_RST & sccsr_pkg::CFG_SSM_MASK)) :
		cfg_wr_val;
	assign cfg_next = watchdog_machine_reset ?
		((cfg_ssm_val & ~sccsr_pkg::CFG_WSM_MASK) |
		(sccsr_pkg::CFG_RST & sccsr_pkg::CFG_WSM_MASK)) :
		cfg_ssm_val;

	wire [15:0] ctl_wr_val = wr_ctl ?
		((ctl_reg & ~ctl_wmask) | (reg_wdata[15:0] & ctl_wmask)) :
		ctl_reg;
	assign ctl_next = safing_machine_reset ?
		((ctl_wr_val & ~sccsr_pkg::CTL_SSM_MASK) |
		(sccsr_pkg::CTL_RST & sccsr_pkg::CTL_SSM_MASK)) :
		ctl_wr_val;

	// Sample count decode
	wire [1:0] sq_code = cfg_next.squib_dc_sample_count;
	wire [1:0] vm_code = cfg_next.voltage_sample_count;
	assign squib_samples_next = (sq_code == 2'h0) ? sccsr_pkg::SAMPLES_8 :
		(sq_code == 2'h1) ? sccsr_pkg::SAMPLES_16 :
		(sq_code == 2'h2) ? sccsr_pkg::SAMPLES_4 :
		sccsr_pkg::SAMPLES_2;
	assign voltage_samples_next = (vm_code == 2'h0) ? sccsr_pkg::SAMPLES_4 :
		(vm_code == 2'h1) ? sccsr_pkg::SAMPLES_16 :
		(vm_code == 2'h2) ? sccsr_pkg::SAMPLES_8 :
		sccsr_pkg::SAMPLES_1;

	wire [1:0] bm_code = ctl_next.battery_monitor_threshold_select;
	assign batt_index_next = (bm_code == 2'h3) ? 2'h0 : bm_code;
	wire [1:0] chg_code = ctl_next.reserve_charge_control;

	// Supply flags: latched ones cleared by reading the status word
	wire [3:0] flag_set = {cmp_sync_reg.pulse_boost_low,
		cmp_sync_reg.sensor_buck_low, cmp_sync_reg.logic_supply_under,
		cmp_sync_reg.logic_supply_over};

	sccsr_sticky #(
		.W(4)
	) u_flags (
		.clk(clk),
		.srst(srst),
		.set(flag_set),
		.clr(rd_power),
		.q(flags_q)
	);

	wire [19:0] power_word = {cmp_sync_reg.wake_pin, cmp_sync_reg.battery_bad,
		cmp_sync_reg.not_battery_good, cmp_sync_reg.input_bad,
		cmp_sync_reg.not_input_good, flags_q[3], flags_q[2],
		cmp_sync_reg.reserve_boost_low, flags_q[1], flags_q[0], 1'b0,
		power_activity};
	wire [19:0] phase_word = {9'h000, oper_phase_reg, 5'h00,
		power_phase_reg};
	wire [15:0] cfg_rd = cfg_reg;
	wire [15:0] ctl_rd = ctl_reg;

	// Sleep register is write-only and reads back zero
	assign reg_rdata_next = hit_cfg ? {4'h0, cfg_rd} :
		hit_ctl ? {4'h0, ctl_rd} :
		hit_phase ? phase_word :
		hit_power ? power_word :
		20'h00000;

	// Pulse boost handling across the reserve phase
	wire hold_on = ctl_next.pulse_boost_hold_in_reserve;
	wire restart_from_boost = ctl_next.pulse_boost_restart_source;

	always_comb begin
		bst_next = bst_reg;
		case (bst_reg)
			sccsr_pkg::BST_FOLLOW: begin
				if (in_reserve) begin
					bst_next = hold_on ? sccsr_pkg::BST_RUN :
						sccsr_pkg::BST_WAIT;
				end
			end
			sccsr_pkg::BST_RUN: begin
				if (!in_reserve) begin
					bst_next = sccsr_pkg::BST_FOLLOW;
				end
			end
			sccsr_pkg::BST_WAIT: begin
				if (!in_reserve) begin
					bst_next = sccsr_pkg::BST_FOLLOW;
				end else if (hold_on) begin
					bst_next = sccsr_pkg::BST_RUN;
				end else if (!restart_from_boost) begin
					if (cmp_sync_reg.input_fast_slope) begin
						bst_next = sccsr_pkg::BST_RUN;
					end
				end else if (cmp_sync_reg.boost_above_restart) begin
					bst_next = sccsr_pkg::BST_ARMED;
				end
			end
			sccsr_pkg::BST_ARMED: begin
				if (!in_reserve) begin
					bst_next = sccsr_pkg::BST_FOLLOW;
				end else if (hold_on) begin
					bst_next = sccsr_pkg::BST_RUN;
				end else if (cmp_sync_reg.boost_below_restart) begin
					bst_next = sccsr_pkg::BST_RUN;
				end
			end
			default: begin
				bst_next = sccsr_pkg::BST_FOLLOW;
			end
		endcase
	end

	// Off request always wins; reserve logic can only suppress it
	assign pulse_boost_next = ctl_next.pulse_boost_on_request &
		((bst_next == sccsr_pkg::BST_FOLLOW) |
		(bst_next == sccsr_pkg::BST_RUN));

	// Comparators are asynchronous levels
	always_ff @(posedge clk) begin
		if (srst) begin
			cmp_meta_reg <= '0;
			cmp_sync_reg <= '0;
		end else begin
			cmp_meta_reg <= cmp_pins;
			cmp_sync_reg <= cmp_meta_reg;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			cfg_reg <= sccsr_pkg::CFG_RST;
			ctl_reg <= sccsr_pkg::CTL_RST;
		end else begin
			cfg_reg <= cfg_next;
			ctl_reg <= ctl_next;
		end
	end

	always_ff @(posedge clk) begin
		if (srst || safing_machine_reset || watchdog_machine_reset) begin
			oper_phase_reg <= sccsr_pkg::OPER_FIRST;
		end else begin
			oper_phase_reg <= operating_phase_code;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			power_phase_reg <= sccsr_pkg::POWER_WAKE;
		end else begin
			power_phase_reg <= power_phase_code;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			reg_rdata_reg <= '0;
			reg_rvalid_reg <= 1'b0;
			reg_unmapped_reg <= 1'b0;
		end else begin
			reg_rdata_reg <= reg_rd ? reg_rdata_next : reg_rdata_reg;
			reg_rvalid_reg <= reg_rd;
			reg_unmapped_reg <= (reg_rd | reg_wr) & ~hit_any;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			power_off_reg <= 1'b0;
			sleep_reg <= 1'b0;
			bst_reg <= sccsr_pkg::BST_FOLLOW;
			pulse_boost_reg <= 1'b1;
		end else begin
			power_off_reg <= power_off_write;
			sleep_reg <= wr_sleep;
			bst_reg <= bst_next;
			pulse_boost_reg <= pulse_boost_next;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			squib_samples_reg <= sccsr_pkg::SAMPLES_8;
			voltage_samples_reg <= sccsr_pkg::SAMPLES_4;
			fall_filter_reg <= FALL_SHORT;
			wd_timeout_enable_reg <= 1'b1;
			batt_index_reg <= 2'h0;
			charge_reg <= 1'b0;
			discharge_reg <= 1'b0;
		end else begin
			squib_samples_reg <= squib_samples_next;
			voltage_samples_reg <= voltage_samples_next;
			fall_filter_reg <= cfg_next.input_good_fall_filter_select ?
				FALL_LONG : FALL_SHORT;
			wd_timeout_enable_reg <=
				~cfg_next.first_watchdog_initial_timeout_disable;
			batt_index_reg <= batt_index_next;
			charge_reg <= chg_code == 2'h1;
			discharge_reg <= chg_code == 2'h2;
		end
	end

	assign reg_rdata = reg_rdata_reg;
	assign reg_rvalid = reg_rvalid_reg;
	assign reg_unmapped = reg_unmapped_reg;
	assign cfg = cfg_reg;
	assign ctl = ctl_reg;
	assign squib_dc_samples = squib_samples_reg;
	assign voltage_samples = voltage_samples_reg;
	assign input_good_fall_filter_cycles = fall_filter_reg;
	// Rise filter is fixed by the hardware
	assign input_good_rise_filter_cycles = FALL_LONG;
	assign first_watchdog_initial_timeout_enable = wd_timeout_enable_reg;
	assign battery_monitor_threshold_index = batt_index_reg;
	assign reserve_charge_enable = charge_reg;
	assign reserve_discharge_enable = discharge_reg;
	assign pulse_boost_enable = pulse_boost_reg;
	assign power_off_pulse = power_off_reg;
	assign sleep_pulse = sleep_reg;
endmodule
`default_nettype wire

// file: sccsr_host.sv
// Purpose: Host model issuing single register accesses to the bank
// Assumes: The bank samples its request inputs on the rising edge
// Notes: Drives on the falling edge so set-up is never marginal
`timescale 1ns/10ps
`default_nettype none
module sccsr_host (
	input wire logic clk,
	output var logic reg_wr,
	output var logic reg_rd,
	output var logic [sccsr_pkg::ADDR_W-1:0] reg_addr,
	output var logic [sccsr_pkg::DATA_W-1:0] reg_wdata,
	input wire logic [sccsr_pkg::DATA_W-1:0] reg_rdata,
	input wire logic reg_rvalid
);
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 7'h00;
		reg_wdata = 20'h00000;
	end
	task automatic wr(input logic [6:0] a, input logic [19:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
		// Stale data would hide a late-sampling bug
		reg_wdata = ~d;
	endtask
	task automatic rd(input logic [6:0] a, output logic [19:0] d);
		int n;
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		n = 0;
		while (reg_rvalid !== 1'b1 && n < 4) begin
			@(negedge clk);
			n++;
		end
		d = (reg_rvalid === 1'b1) ? reg_rdata : 20'hXXXXX;
	endtask
endmodule
`default_nettype wire

// file: sccsr_regs_asserts.sv
// Purpose: Port-level checks of the system config/state bank
// Assumes: Single clock domain, srst synchronous active high
// Notes: Decoded outputs are checked against their register fields
`timescale 1ns/10ps
`default_nettype none
module sccsr_regs_asserts #(
	parameter int FILT_W = 10
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic safing_machine_reset,
	input wire logic watchdog_machine_reset,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [sccsr_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [sccsr_pkg::DATA_W-1:0] reg_wdata,
	input wire logic [sccsr_pkg::DATA_W-1:0] reg_rdata,
	input wire logic [2:0] power_phase_code,
	input wire sccsr_pkg::sccsr_cfg_t cfg,
	input wire sccsr_pkg::sccsr_ctl_t ctl,
	input wire logic [4:0] squib_dc_samples,
	input wire logic [4:0] voltage_samples,
	input wire logic [FILT_W-1:0] input_good_fall_filter_cycles,
	input wire logic [FILT_W-1:0] input_good_rise_filter_cycles,
	input wire logic first_watchdog_initial_timeout_enable,
	input wire logic [1:0] battery_monitor_threshold_index,
	input wire logic reserve_charge_enable,
	input wire logic reserve_discharge_enable,
	input wire logic power_off_pulse,
	input wire logic sleep_pulse
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	wire logic [1:0] sqc = cfg.squib_dc_sample_count;
	wire logic [1:0] vc = cfg.voltage_sample_count;
	wire logic [1:0] bt = ctl.battery_monitor_threshold_select;
	wire logic no_mrst = !safing_machine_reset && !watchdog_machine_reset;
	wire logic cfg_wr = reg_wr && reg_addr == sccsr_pkg::ID_SYS_CONFIG;
	wire logic ro_wr = reg_wr && reg_addr == sccsr_pkg::ID_PHASE_REPORT;
	wire logic off_wr = reg_wr && reg_addr == sccsr_pkg::ID_SYS_CONTROL
		&& reg_wdata[4] && !safing_machine_reset
		&& power_phase_code == sccsr_pkg::POWER_SHUTDOWN;
	property p_sq;
		squib_dc_samples == (sqc == 2'h0 ? 5'h08 : sqc == 2'h1 ? 5'h10 :
			sqc == 2'h2 ? 5'h04 : 5'h02);
	endproperty
	a_sq: assert property (p_sq) else $error("squib sample count bad");
	property p_vs;
		voltage_samples == (vc == 2'h0 ? 5'h04 : vc == 2'h1 ? 5'h10 :
			vc == 2'h2 ? 5'h08 : 5'h01);
	endproperty
	a_vs: assert property (p_vs) else $error("voltage sample count bad");
	property p_filt;
		input_good_rise_filter_cycles == FILT_W'(sccsr_pkg::FILT_LONG_CYC) &&
		input_good_fall_filter_cycles == (cfg.input_good_fall_filter_select ?
		FILT_W'(sccsr_pkg::FILT_LONG_CYC) : FILT_W'(sccsr_pkg::FILT_SHORT_CYC));
	endproperty
	a_filt: assert property (p_filt) else $error("filter time bad");
	property p_wd;
		cfg_wr && no_mrst |=>
			first_watchdog_initial_timeout_enable == !$past(reg_wdata[0]);
	endproperty
	a_wd: assert property (p_wd) else $error("timeout enable bad");
	property p_thr;
		battery_monitor_threshold_index == (bt == 2'h3 ? 2'h0 : bt);
	endproperty
	a_thr: assert property (p_thr) else $error("threshold index bad");
	property p_chg;
		reserve_charge_enable == (ctl.reserve_charge_control == 2'h1) &&
		reserve_discharge_enable == (ctl.reserve_charge_control == 2'h2);
	endproperty
	a_chg: assert property (p_chg) else $error("charge control bad");
	property p_poff;
		off_wr |=> power_off_pulse ##1 power_off_pulse == $past(off_wr);
	endproperty
	a_poff: assert property (p_poff) else $error("power off missing");
	property p_poff_no;
		power_phase_code != sccsr_pkg::POWER_SHUTDOWN |=> !power_off_pulse;
	endproperty
	a_poff_no: assert property (p_poff_no) else $error("stray power off");
	property p_slp;
		reg_wr && reg_addr == sccsr_pkg::ID_SLEEP_COMMAND |=> sleep_pulse;
	endproperty
	a_slp: assert property (p_slp) else $error("sleep pulse missing");
	property p_ssm;
		safing_machine_reset |=> cfg.passenger_inhibit_source_select &&
			cfg.safing_engine_source_select && sqc == 2'h0 && vc == 2'h0 &&
			ctl.reserve_boost_on_request && ctl.pulse_boost_on_request;
	endproperty
	a_ssm: assert property (p_ssm) else $error("safing reset bad");
	property p_ro;
		ro_wr && no_mrst |=> $stable(cfg) && $stable(ctl);
	endproperty
	a_ro: assert property (p_ro) else $error("read-only write took");
	property p_zero;
		reg_rd && reg_addr != sccsr_pkg::ID_POWER_STATUS |=>
			reg_rdata[19:16] == 4'h0;
	endproperty
	a_zero: assert property (p_zero) else $error("unused bits set");
	c_slp: cover property (sleep_pulse);
	c_poff: cover property (power_off_pulse);
	c_ssm: cover property (safing_machine_reset ##1 cfg_wr);
endmodule
bind sccsr_regs sccsr_regs_asserts #(.FILT_W(FILT_W)) u_chk (.clk(clk),
	.srst(srst), .safing_machine_reset(safing_machine_reset),
	.watchdog_machine_reset(watchdog_machine_reset), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata), .power_phase_code(power_phase_code), .cfg(cfg),
	.ctl(ctl), .squib_dc_samples(squib_dc_samples),
	.voltage_samples(voltage_samples),
	.input_good_fall_filter_cycles(input_good_fall_filter_cycles),
	.input_good_rise_filter_cycles(input_good_rise_filter_cycles),
	.first_watchdog_initial_timeout_enable(first_watchdog_initial_timeout_enable),
	.battery_monitor_threshold_index(battery_monitor_threshold_index),
	.reserve_charge_enable(reserve_charge_enable),
	.reserve_discharge_enable(reserve_discharge_enable),
	.power_off_pulse(power_off_pulse), .sleep_pulse(sleep_pulse));
`default_nettype wire

// file: tb.sv
// Purpose: Self-checking bench for the system config/state bank
// Assumes: Host model drives accesses on falling edges
// Notes: Comparator levels need two sync cycles before they show
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic clk, srst, ssr, wsr, wr, rd, rvalid, unm, wd_en;
	logic chg, dis, pb_en, poff, slp;
	logic [6:0] addr;
	logic [19:0] wdata, rdata, d;
	logic [2:0] op_code, pw_code;
	logic [8:0] act;
	logic [4:0] sq_n, v_n;
	logic [9:0] fall_f, rise_f;
	logic [1:0] thr;
	sccsr_pkg::sccsr_cmp_t cmp;
	sccsr_pkg::sccsr_cfg_t cfg;
	sccsr_pkg::sccsr_ctl_t ctl;
	int num_errors = 0, checked = 0, cycles = 0;
	logic [4:0] sq_tab [4] = '{5'h08, 5'h10, 5'h04, 5'h02};
	logic [4:0] v_tab [4] = '{5'h04, 5'h10, 5'h08, 5'h01};
	sccsr_host u_sccsr_host (.clk(clk), .reg_wr(wr), .reg_rd(rd),
		.reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
		.reg_rvalid(rvalid));
	sccsr_regs u_sccsr_regs (.clk(clk), .srst(srst),
		.safing_machine_reset(ssr), .watchdog_machine_reset(wsr),
		.reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata),
		.reg_rdata(rdata), .reg_rvalid(rvalid), .reg_unmapped(unm),
		.operating_phase_code(op_code), .power_phase_code(pw_code),
		.power_activity(act), .cmp_pins(cmp), .cfg(cfg), .ctl(ctl),
		.squib_dc_samples(sq_n), .voltage_samples(v_n),
		.input_good_fall_filter_cycles(fall_f),
		.input_good_rise_filter_cycles(rise_f),
		.first_watchdog_initial_timeout_enable(wd_en),
		.battery_monitor_threshold_index(thr),
		.reserve_charge_enable(chg), .reserve_discharge_enable(dis),
		.pulse_boost_enable(pb_en), .power_off_pulse(poff),
		.sleep_pulse(slp));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic summarize();
		$display("comparisons %0d, mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string what, input logic [19:0] e,
		input logic [19:0] g);
		checked++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", what, e, g);
		end
	endtask
	task automatic rdc(input logic [6:0] a, input logic [19:0] e);
		u_sccsr_host.rd(a, d);
		chk($sformatf("read %h", a), e, d);
	endtask
	task automatic pulse(ref logic s);
		@(negedge clk) s = 1'b1;
		@(negedge clk) s = 1'b0;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			summarize();
		end
	end
	initial begin
		srst = 1'b1;
		{ssr, wsr} = 2'b00;
		op_code = 3'h0;
		pw_code = 3'h0;
		act = 9'h0A5;
		cmp = '0;
		repeat (8) @(posedge clk);
		@(negedge clk) srst = 1'b0;
		rdc(sccsr_pkg::ID_SYS_CONFIG, 20'h01808);
		rdc(sccsr_pkg::ID_SYS_CONTROL, 20'h02060);
		rdc(sccsr_pkg::ID_SLEEP_COMMAND, 20'h00000);
		chk("fall filter", 20'(sccsr_pkg::FILT_SHORT_CYC), 20'(fall_f));
		chk("wd enable", 20'h1, 20'(wd_en));
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			u_sccsr_host.wr(sccsr_pkg::ID_SYS_CONFIG, 20'((i << 7) | (i << 5)));
			chk("squib samples", 20'(sq_tab[i]), 20'(sq_n));
			chk("volt samples", 20'(v_tab[i]), 20'(v_n));
			u_sccsr_host.wr(sccsr_pkg::ID_SYS_CONTROL,
				20'((i << 10) | (i << 7) | 32'h267));
			chk("threshold", 20'(i == 3 ? 0 : i), 20'(thr));
			chk("charge", 20'(i == 1), 20'(chg));
			chk("discharge", 20'(i == 2), 20'(dis));
			chk("boost", 20'h1, 20'(pb_en));
		end
		u_sccsr_host.wr(sccsr_pkg::ID_SYS_CONFIG, 20'hFFFFF);
		rdc(sccsr_pkg::ID_SYS_CONFIG, 20'h0BFFF);
		chk("fall filter", 20'(sccsr_pkg::FILT_LONG_CYC), 20'(fall_f));
		chk("rise filter", 20'(sccsr_pkg::FILT_LONG_CYC), 20'(rise_f));
		chk("wd enable", 20'h0, 20'(wd_en));
		$display("test fields done");
		pulse(ssr);
		rdc(sccsr_pkg::ID_SYS_CONFIG, 20'h0180B);
		rdc(sccsr_pkg::ID_SYS_CONTROL, 20'h02064);
		u_sccsr_host.wr(sccsr_pkg::ID_SYS_CONFIG, 20'hFFFFF);
		pulse(wsr);
		rdc(sccsr_pkg::ID_SYS_CONFIG, 20'h0180A);
		$display("test machine resets done");
		pw_code = 3'h2;
		u_sccsr_host.wr(sccsr_pkg::ID_SYS_CONTROL, 20'h02070);
		chk("power off", 20'h0, 20'(poff));
		rdc(sccsr_pkg::ID_SYS_CONTROL, 20'h02060);
		pw_code = 3'h4;
		u_sccsr_host.wr(sccsr_pkg::ID_SYS_CONTROL, 20'h02070);
		chk("power off", 20'h1, 20'(poff));
		u_sccsr_host.wr(sccsr_pkg::ID_SLEEP_COMMAND, 20'h5A5A5);
		chk("sleep", 20'h1, 20'(slp));
		rdc(sccsr_pkg::ID_SLEEP_COMMAND, 20'h00000);
		op_code = 3'h4;
		u_sccsr_host.wr(sccsr_pkg::ID_PHASE_REPORT, 20'hFFFFF);
		rdc(sccsr_pkg::ID_PHASE_REPORT, 20'h00404);
		u_sccsr_host.wr(7'h7F, 20'h00000);
		chk("unmapped", 20'h1, 20'(unm));
		$display("test commands done");
		cmp.wake_pin = 1'b1;
		cmp.pulse_boost_low = 1'b1;
		repeat (4) @(negedge clk);
		cmp.pulse_boost_low = 1'b0;
		repeat (4) @(negedge clk);
		rdc(sccsr_pkg::ID_POWER_STATUS, 20'h840A5);
		rdc(sccsr_pkg::ID_POWER_STATUS, 20'h800A5);
		$display("test status done");
		u_sccsr_host.wr(sccsr_pkg::ID_SYS_CONTROL, 20'h00060);
		pw_code = 3'h3;
		repeat (4) @(negedge clk);
		chk("boost", 20'h0, 20'(pb_en));
		cmp.input_fast_slope = 1'b1;
		repeat (4) @(negedge clk);
		chk("boost", 20'h1, 20'(pb_en));
		pw_code = 3'h2;
		u_sccsr_host.wr(sccsr_pkg::ID_SYS_CONTROL, 20'h08060);
		pw_code = 3'h3;
		cmp.boost_below_restart = 1'b1;
		repeat (4) @(negedge clk);
		chk("boost", 20'h0, 20'(pb_en));
		cmp.boost_below_restart = 1'b0;
		cmp.boost_above_restart = 1'b1;
		repeat (4) @(negedge clk);
		chk("boost", 20'h0, 20'(pb_en));
		cmp.boost_above_restart = 1'b0;
		cmp.boost_below_restart = 1'b1;
		repeat (4) @(negedge clk);
		chk("boost", 20'h1, 20'(pb_en));
		pw_code = 3'h2;
		repeat (2) @(negedge clk);
		pw_code = 3'h3;
		repeat (2) @(negedge clk);
		chk("boost", 20'h0, 20'(pb_en));
		u_sccsr_host.wr(sccsr_pkg::ID_SYS_CONTROL, 20'h0A060);
		chk("boost", 20'h1, 20'(pb_en));
		$display("test reserve done");
		summarize();
	end
endmodule
`default_nettype wire
